// >>> rtl/ptm_block.sv
// Our own choices: the register offsets and the APB register port.
module ptm_block
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // fabric pins, asynchronous to pclk
  input  wire logic [31:0] route_in,
  input  wire logic [3:0]  clk_pin,
  input  wire logic [3:0]  global_in,
  // macrocell results
  output logic      [15:0] mc_out
);

  // whole state of the block, apart from the macrocell registers
  typedef struct packed {
    logic [ptm_pkg::NUM_IN-1:0]          rte_s1;  // sync stage one
    logic [ptm_pkg::NUM_IN-1:0]          rte_s2;  // sync stage two
    logic [ptm_pkg::NUM_PIN-1:0]         pin_s1;
    logic [ptm_pkg::NUM_PIN-1:0]         pin_s2;
    logic [ptm_pkg::NUM_GLB-1:0]         glb_s1;
    logic [ptm_pkg::NUM_GLB-1:0]         glb_s2;
    logic [1:0]                          clk_prev; // last clock level
    ptm_pkg::ptm_ctl_t [1:0]             clk_cfg;
    ptm_pkg::ptm_ctl_t [1:0]             clr_cfg;
    ptm_pkg::ptm_mc_cfg_t [ptm_pkg::NUM_MC-1:0] mc_cfg;
    ptm_pkg::ptm_pt_t [ptm_pkg::NUM_PT-1:0]     pt_cfg;
    logic [31:0]                         prdata;
    logic                                pready;
    logic                                pslverr;
  } ptm_st_t;

  ptm_st_t st, next_st;

  logic [ptm_pkg::NUM_LIT-1:0] lits;      // product-term literals
  logic [1:0]                  clk_lvl;   // selected clock levels
  logic [1:0]                  clk_tick;  // gated edge pulses
  logic [1:0]                  clr_lvl;   // clears after polarity
  logic [ptm_pkg::NUM_MC:0]    exp_chain; // expander links
  logic                        setup;     // apb setup phase
  logic                        wr_go;     // write takes effect
  logic [31:0]                 rd_word;   // decoded read value
  logic                        rd_err;    // unmapped address
  logic [11:0]                 pt_off;    // offset in term area
  logic [ptm_pkg::PT_SEL_W-1:0] pt_sel;   // term addressed
  logic [1:0]                  pt_word;   // word in term slot
  logic [ptm_pkg::MC_SEL_W-1:0] mc_sel;   // macrocell addressed
  logic                        in_mc;     // hit in cell area
  logic                        in_pt;     // hit in term area

  // picks a control source level from pins, globals or routing
  function automatic logic pick_src
  (
    input ptm_pkg::ptm_ctl_t           c,
    input logic [ptm_pkg::NUM_PIN-1:0] pins,
    input logic [ptm_pkg::NUM_GLB-1:0] glb,
    input logic [ptm_pkg::NUM_IN-1:0]  rte
  );
    logic v;
    v = 1'b0;
    unique case (c.src)
      ptm_pkg::PTM_SRC_PIN: v = pins[c.idx[ptm_pkg::PIN_SEL_W-1:0]];
      ptm_pkg::PTM_SRC_GLB: v = glb[c.idx[ptm_pkg::PIN_SEL_W-1:0]];
      ptm_pkg::PTM_SRC_RTE: v = rte[c.idx];
      ptm_pkg::PTM_SRC_OFF: v = 1'b0;
    endcase
    return v;
  endfunction : pick_src

  // literal vector: routing inputs then fed-back cells
  always_comb
  begin
    lits = {mc_out[ptm_pkg::NUM_FB-1:0], st.rte_s2};
  end

  // block-wide clocks, enables and clears
  always_comb
  begin
    for (int c = 0; c < ptm_pkg::NUM_BCLK; c++)
    begin
      clk_lvl[c] = pick_src(st.clk_cfg[c], st.pin_s2, st.glb_s2,
                            st.rte_s2);
      clk_tick[c] = (clk_lvl[c] ^ st.clk_prev[c])
                  & (clk_lvl[c] ^ st.clk_cfg[c].alt)
                  & st.rte_s2[st.clk_cfg[c].ena_idx];
      clr_lvl[c] = pick_src(st.clr_cfg[c], st.pin_s2, st.glb_s2,
                            st.rte_s2) ^ st.clr_cfg[c].alt;
    end
  end

  // apb address decode, areas are word aligned
  always_comb
  begin
    pt_off  = paddr - ptm_pkg::A_PT_LO;
    pt_sel  = pt_off[ptm_pkg::PT_LSB +: ptm_pkg::PT_SEL_W];
    pt_word = pt_off[ptm_pkg::WORD_LSB +: 2];
    mc_sel  = paddr[ptm_pkg::WORD_LSB +: ptm_pkg::MC_SEL_W];
    in_mc   = (paddr >= ptm_pkg::A_MC_LO) && (paddr <= ptm_pkg::A_MC_HI);
    in_pt   = (paddr >= ptm_pkg::A_PT_LO) && (paddr <= ptm_pkg::A_PT_HI);
  end

  // read mux, unmapped or unaligned answers with an error
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_err  = 1'b0;
    if (paddr[ptm_pkg::WORD_LSB-1:0] != 2'h0)
      rd_err = 1'b1;
    else if (in_mc)
      rd_word[ptm_pkg::MC_W-1:0] = st.mc_cfg[mc_sel];
    else if (in_pt)
    begin
      // literal masks split into a low word and a high part
      unique case (pt_word)
        ptm_pkg::PT_T_LO:
          rd_word = st.pt_cfg[pt_sel].t[ptm_pkg::NUM_IN-1:0];
        ptm_pkg::PT_T_HI:
          rd_word[ptm_pkg::NUM_FB-1:0] =
            st.pt_cfg[pt_sel].t[ptm_pkg::NUM_LIT-1:ptm_pkg::NUM_IN];
        ptm_pkg::PT_C_LO:
          rd_word = st.pt_cfg[pt_sel].c[ptm_pkg::NUM_IN-1:0];
        ptm_pkg::PT_C_HI:
          rd_word[ptm_pkg::NUM_FB-1:0] =
            st.pt_cfg[pt_sel].c[ptm_pkg::NUM_LIT-1:ptm_pkg::NUM_IN];
      endcase
    end
    else
    begin
      unique case (paddr)
        ptm_pkg::A_CLK0:
          rd_word[ptm_pkg::CTL_W-1:0] = st.clk_cfg[0];
        ptm_pkg::A_CLK1:
          rd_word[ptm_pkg::CTL_W-1:0] = st.clk_cfg[1];
        ptm_pkg::A_CLR0:
          rd_word[ptm_pkg::CTL_W-1:0] = st.clr_cfg[0];
        ptm_pkg::A_CLR1:
          rd_word[ptm_pkg::CTL_W-1:0] = st.clr_cfg[1];
        // live macrocell results
        ptm_pkg::A_STAT:
          rd_word[ptm_pkg::NUM_MC-1:0] = mc_out;
        // synchronised routing inputs
        ptm_pkg::A_INSTAT:
          rd_word = st.rte_s2;
        default:
          rd_err = 1'b1;
      endcase
    end
  end

  // next state: synchronisers, clock history, apb and config
  always_comb
  begin
    next_st = st;
    // pins pass two flops before any logic reads them
    next_st.rte_s1 = route_in;
    next_st.rte_s2 = st.rte_s1;
    next_st.pin_s1 = clk_pin;
    next_st.pin_s2 = st.pin_s1;
    next_st.glb_s1 = global_in;
    next_st.glb_s2 = st.glb_s1;
    next_st.clk_prev = clk_lvl;

    // answer prepared in setup so pready rises with penable
    setup = psel & ~penable;
    wr_go = psel & penable & st.pready & pwrite & ~st.pslverr;
    next_st.pready = 1'b0;
    if (setup)
    begin
      next_st.pready  = 1'b1;
      next_st.pslverr = rd_err;
      next_st.prdata  = pwrite ? 32'h0000_0000 : rd_word;
    end
    else if (psel & penable & st.pready)
    begin
      next_st.pslverr = 1'b0;
    end

    // register writes, read-only words ignore them
    if (wr_go)
    begin
      if (in_mc)
        next_st.mc_cfg[mc_sel] = pwdata[ptm_pkg::MC_W-1:0];
      else if (in_pt)
      begin
        unique case (pt_word)
          ptm_pkg::PT_T_LO:
            next_st.pt_cfg[pt_sel].t[ptm_pkg::NUM_IN-1:0] = pwdata;
          ptm_pkg::PT_T_HI:
            next_st.pt_cfg[pt_sel].t[ptm_pkg::NUM_LIT-1:ptm_pkg::NUM_IN] =
              pwdata[ptm_pkg::NUM_FB-1:0];
          ptm_pkg::PT_C_LO:
            next_st.pt_cfg[pt_sel].c[ptm_pkg::NUM_IN-1:0] = pwdata;
          ptm_pkg::PT_C_HI:
            next_st.pt_cfg[pt_sel].c[ptm_pkg::NUM_LIT-1:ptm_pkg::NUM_IN] =
              pwdata[ptm_pkg::NUM_FB-1:0];
        endcase
      end
      else
      begin
        unique case (paddr)
          ptm_pkg::A_CLK0:
            next_st.clk_cfg[0] = pwdata[ptm_pkg::CTL_W-1:0];
          ptm_pkg::A_CLK1:
            next_st.clk_cfg[1] = pwdata[ptm_pkg::CTL_W-1:0];
          ptm_pkg::A_CLR0:
            next_st.clr_cfg[0] = pwdata[ptm_pkg::CTL_W-1:0];
          ptm_pkg::A_CLR1:
            next_st.clr_cfg[1] = pwdata[ptm_pkg::CTL_W-1:0];
          // status words are read only
          default:
            next_st.pready = 1'b0;
        endcase
      end
    end
  end

  // state register, constants only under reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st          <= '0;
      st.clk_cfg  <= {ptm_pkg::CTL_RST, ptm_pkg::CTL_RST};
      st.clr_cfg  <= {ptm_pkg::CTL_RST, ptm_pkg::CTL_RST};
      st.mc_cfg   <= {ptm_pkg::NUM_MC{ptm_pkg::MC_RST}};
      st.pt_cfg   <= {ptm_pkg::NUM_PT{ptm_pkg::PT_RST}};
    end
    else
    begin
      st <= next_st;
    end
  end

  // apb outputs straight from the state flops
  assign prdata  = st.prdata;
  assign pready  = st.pready;
  assign pslverr = st.pslverr;

  // first cell has nothing to borrow from
  assign exp_chain[0] = 1'b0;

  // sixteen cells, expander runs from cell i to cell i+1
  // sixteen macrocells
  for (genvar i = 0; i < ptm_pkg::NUM_MC; i++)
  begin : g_mc
    // two terms and one register each
    ptm_macrocell u_mc
    (
      .pclk     (pclk),
      .presetn  (presetn),
      .lits     (lits),
      .pt_cfg   (st.pt_cfg[2*i+1 -: 2]),
      .cfg      (st.mc_cfg[i]),
      .clk_tick (clk_tick),
      .clr_lvl  (clr_lvl),
      .exp_in   (exp_chain[i]),
      .exp_out  (exp_chain[i+1]),
      .mc_out   (mc_out[i])
    );
  end

endmodule : ptm_block

// >>> rtl/ptm_pkg.sv
package ptm_pkg;

  // block dimensions
  localparam int NUM_IN    = 32;  // local routing inputs
  localparam int NUM_FB    = 9;   // macrocells fed back
  localparam int NUM_MC    = 16;  // macrocells per block
  localparam int NUM_PT    = 32;  // product terms per block
  localparam int NUM_LIT   = NUM_IN + NUM_FB;
  localparam int NUM_PIN   = 4;   // dedicated clock pins
  localparam int NUM_GLB   = 4;   // global signals
  localparam int NUM_BCLK  = 2;   // block-wide clocks and clears
  localparam int PT_PER_MC = 2;
  localparam int IDX_W     = 5;
  localparam int PIN_SEL_W = 2;

  // apb address map
  localparam int          ADDR_W   = 12;
  localparam int          DATA_W   = 32;
  localparam logic [11:0] A_CLK0   = 12'h004;
  localparam logic [11:0] A_CLK1   = 12'h008;
  localparam logic [11:0] A_CLR0   = 12'h00c;
  localparam logic [11:0] A_CLR1   = 12'h010;
  localparam logic [11:0] A_STAT   = 12'h014;
  localparam logic [11:0] A_INSTAT = 12'h018;
  localparam logic [11:0] A_MC_LO  = 12'h040;
  localparam logic [11:0] A_MC_HI  = 12'h07c;
  localparam logic [11:0] A_PT_LO  = 12'h100;
  localparam logic [11:0] A_PT_HI  = 12'h2fc;
  localparam int          WORD_LSB = 2;
  localparam int          MC_SEL_W = 4;
  localparam int          PT_LSB   = 4;
  localparam int          PT_SEL_W = 5;
  // word select inside one product-term slot
  localparam logic [1:0]  PT_T_LO  = 2'h0;
  localparam logic [1:0]  PT_T_HI  = 2'h1;
  localparam logic [1:0]  PT_C_LO  = 2'h2;
  localparam logic [1:0]  PT_C_HI  = 2'h3;

  typedef enum logic [1:0] {PTM_SRC_PIN, PTM_SRC_GLB, PTM_SRC_RTE,
                            PTM_SRC_OFF} ptm_src_t;
  typedef enum logic [1:0] {PTM_FF_D, PTM_FF_T, PTM_FF_JK,
                            PTM_FF_SR} ptm_ff_t;
  typedef enum logic [1:0] {PTM_CLR_NONE, PTM_CLR_0, PTM_CLR_1,
                            PTM_CLR_NONE2} ptm_clr_t;

  // clock or clear control word, bits 12:0
  typedef struct packed {
    logic [IDX_W-1:0] ena_idx;  // clock enable routing line
    logic             alt;      // falling edge / inverted clear
    logic [IDX_W-1:0] idx;      // source index
    ptm_src_t         src;
  } ptm_ctl_t;
  localparam int CTL_W = $bits(ptm_ctl_t);

  // macrocell configuration word, bits 8:0
  typedef struct packed {
    logic     xor1;    // pt1 drives the xor instead of the or
    logic     lend;    // pass or result, before the xor, on as parallel expander
    logic     inv1;    // invert pt1
    ptm_clr_t clrsel;
    logic     clksel;
    logic     bypass;
    ptm_ff_t  fftype;
  } ptm_mc_cfg_t;
  localparam int MC_W = $bits(ptm_mc_cfg_t);

  // one product term: true and complement literal masks
  typedef struct packed {
    logic [NUM_LIT-1:0] t;
    logic [NUM_LIT-1:0] c;
  } ptm_pt_t;

  localparam ptm_ctl_t    CTL_RST = '{ena_idx: 5'h00, alt: 1'b0,
                                      idx: 5'h00, src: PTM_SRC_OFF};
  localparam ptm_mc_cfg_t MC_RST  = ptm_mc_cfg_t'(9'h000);
  localparam ptm_pt_t     PT_RST  = ptm_pt_t'(82'h0);

endpackage : ptm_pkg

// >>> rtl/ptm_macrocell.sv
module ptm_macrocell
(
  // clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // literals and configuration
  input  wire logic [ptm_pkg::NUM_LIT-1:0] lits,
  input  ptm_pkg::ptm_pt_t [1:0]           pt_cfg,
  input  ptm_pkg::ptm_mc_cfg_t             cfg,
  // block-wide clock ticks and clear levels
  input  wire logic [1:0]                 clk_tick,
  input  wire logic [1:0]                 clr_lvl,
  // expander chain
  input  wire logic                       exp_in,
  output logic                            exp_out,
  // macrocell result
  output logic                            mc_out
);

  // whole state of one macrocell
  typedef struct packed {
    logic q;    // programmable register
    logic out;  // output stage
  } ptm_mc_st_t;

  ptm_mc_st_t st, next_st;
  logic [1:0] pt;       // product terms
  logic       p1;       // pt1 after optional inversion
  logic       own_or;   // own or-gate terms
  logic       sum;      // or/xor result
  logic       tick;     // selected clock tick
  logic       clr;      // selected clear

  // product terms, an empty mask pair means unused (zero)
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      pt[i] = (|(pt_cfg[i].t | pt_cfg[i].c))
            & (&((lits | ~pt_cfg[i].t) & (~lits | ~pt_cfg[i].c)));
    end
  end

  // or/xor gating and expander pass-on
  always_comb
  begin
    p1     = pt[1] ^ cfg.inv1;
    // pt to or, xor or expander
    own_or = pt[0] | (p1 & ~cfg.xor1);
    sum    = (own_or | exp_in) ^ (p1 & cfg.xor1);
    exp_out = cfg.lend & (own_or | exp_in);
  end

  // register type, clock, clear and output
  always_comb
  begin
    next_st = st;
    tick = clk_tick[cfg.clksel];
    unique case (cfg.clrsel)
      ptm_pkg::PTM_CLR_0: clr = clr_lvl[0];
      ptm_pkg::PTM_CLR_1: clr = clr_lvl[1];
      default:            clr = 1'b0;
    endcase
    if (tick)
    begin
      // d, t, jk or sr behaviour
      unique case (cfg.fftype)
        ptm_pkg::PTM_FF_D:  next_st.q = sum;
        ptm_pkg::PTM_FF_T:  next_st.q = st.q ^ sum;
        ptm_pkg::PTM_FF_JK: next_st.q = (pt[0] & ~st.q) | (~p1 & st.q);
        ptm_pkg::PTM_FF_SR: next_st.q = pt[0] | (~p1 & st.q);
      endcase
    end
    if (clr)
      next_st.q = 1'b0;
    // each cell chooses on its own
    next_st.out = cfg.bypass ? sum : next_st.q;
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign mc_out = st.out;

endmodule : ptm_macrocell

// >>> tb/ptm_block_monitor.sv
module ptm_block_monitor
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb slave side
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // fabric side
  input wire logic [31:0] route_in,
  input wire logic [15:0] mc_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic        mapped;   // aligned and inside a window
  logic [2:0]  age;      // edges the routing has been still
  logic [31:0] rte_prev; // routing seen at last edge

  // decode of the register windows
  always_comb
  begin
    mapped = paddr[1:0] == 2'h0 &&
      ((paddr >= ptm_pkg::A_CLK0 && paddr <= ptm_pkg::A_INSTAT) ||
       (paddr >= ptm_pkg::A_MC_LO && paddr <= ptm_pkg::A_MC_HI) ||
       (paddr >= ptm_pkg::A_PT_LO && paddr <= ptm_pkg::A_PT_HI));
  end

  // quiet time of the routing, so the sync chain has settled
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rte_prev <= 32'h0;
      age      <= 3'h0;
    end
    else
    begin
      rte_prev <= route_in;
      if (route_in != rte_prev)
        age <= 3'h0;
      else if (age != 3'h7)
        age <= age + 3'h1;
    end
  end

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready && !pwrite;
  endsequence

  a_ready_after: assert property (s_setup |=> pready)
    else $error("no answer after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  a_err_unmapped: assert property
    (s_setup ##0 !mapped |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_ok_mapped: assert property (s_setup ##0 mapped |=> !pslverr)
    else $error("mapped access refused");
  a_err_unaligned: assert property
    (s_setup ##0 paddr[1:0] != 2'h0 |=> pslverr)
    else $error("unaligned access not refused");
  // error flag only pulses with ready, read data holds until setup
  a_hold_read: assert property
    (!$past(psel && !penable) |-> $stable(prdata) && (pready || !pslverr))
    else $error("read answer moved without setup");
  a_stat_mirror: assert property
    (s_access ##0 paddr == ptm_pkg::A_STAT
      |-> prdata[15:0] == $past(mc_out))
    else $error("status read differs from cell outputs");
  a_route_sync: assert property
    (s_access ##0 paddr == ptm_pkg::A_INSTAT ##0 age >= 3'h5
      |-> prdata == route_in)
    else $error("routing read differs from inputs");
endmodule : ptm_block_monitor

bind ptm_block ptm_block_monitor u_mon
(
  .pclk     (pclk),
  .presetn  (presetn),
  .psel     (psel),
  .penable  (penable),
  .pwrite   (pwrite),
  .paddr    (paddr),
  .prdata   (prdata),
  .pready   (pready),
  .pslverr  (pslverr),
  .route_in (route_in),
  .mc_out   (mc_out)
);

// >>> tb/ptm_fabric_model.sv
module ptm_fabric_model
(
  // clock
  input  wire logic        pclk,
  // fabric drive into the block
  output logic      [31:0] route_in,
  output logic      [3:0]  clk_pin,
  output logic      [3:0]  global_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // all lines idle low from time zero
  initial
  begin
    route_in  = 32'h0;
    clk_pin   = 4'h0;
    global_in = 4'h0;
  end

  // k: 0 routing, 1 clock pin, 2 global; held 6 edges so a
  // level always outlives the two-flop sync in the block
  // level held past sync
  task drive(input int k, input int i, input logic v);
    @(posedge pclk);
    if (k == 0)
      route_in[i] <= v;
    else if (k == 1)
      clk_pin[i] <= v;
    else
      global_in[i] <= v;
    repeat (6) @(posedge pclk);
  endtask : drive
endmodule : ptm_fabric_model

// >>> tb/ptm_block_tb.sv
module ptm_block_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        pclk    = 1'b0;  // 200 MHz
  logic        presetn = 1'b0;  // async, active low
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] route_in;
  logic [3:0]  clk_pin;
  logic [3:0]  global_in;
  logic [15:0] mc_out;
  logic [31:0] rd;              // last read data
  logic        er;              // last error flag
  int          n_mismatch   = 0;
  int          total_checks = 0;
  int          cyc          = 0;

  always #2.5 pclk = ~pclk;

  ptm_block u_dut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .route_in(route_in),
    .clk_pin(clk_pin), .global_in(global_in), .mc_out(mc_out)
  );

  ptm_fabric_model u_fab
  (
    .pclk(pclk), .route_in(route_in), .clk_pin(clk_pin),
    .global_in(global_in)
  );

  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // one apb transfer; waits for pready, only the hang guard ends a wait that never sees it
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    paddr   <= a;
    pwrite  <= w;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask : wr

  task rdc(input logic [11:0] a, input logic [31:0] x, input logic e);
    apb(a, 1'b0, 32'h0);
    check(rd, x);
    check({31'h0, er}, {31'h0, e});
  endtask : rdc

  // wait for sync, tick and register, then look at the cells
  task mcheck(input logic [15:0] m, input logic [15:0] x);
    repeat (8) @(posedge pclk);
    check({16'h0, mc_out & m}, {16'h0, x});
  endtask : mcheck

  // hang guard, far above the roughly 480 cycles needed
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      n_mismatch++;
      give_verdict();
    end
  end

  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdc(12'h004, 32'h3, 1'b0);
    rdc(12'h040, 32'h0, 1'b0);
    rdc(12'h100, 32'h0, 1'b0);
    rdc(12'h020, 32'h0, 1'b1);
    rdc(12'h006, 32'h0, 1'b1);
    wr(12'h014, 32'hffff);
    rdc(12'h014, 32'h0, 1'b0);
    // bypass cells: route0, inverted empty term, lent sum, feedback
    wr(12'h040, 32'h4);
    wr(12'h100, 32'h1);
    wr(12'h044, 32'h44);
    wr(12'h050, 32'h84);
    wr(12'h180, 32'h8);
    wr(12'h054, 32'h4);
    wr(12'h058, 32'h4);
    wr(12'h1c4, 32'h1);
    rdc(12'h044, 32'h44, 1'b0);
    u_fab.drive(0, 0, 1'b1);
    u_fab.drive(0, 3, 1'b1);
    mcheck(16'h0073, 16'h0073);
    rdc(12'h018, 32'h9, 1'b0);
    u_fab.drive(0, 0, 1'b0);
    u_fab.drive(0, 3, 1'b0);
    mcheck(16'h0073, 16'h0002);
    // cell 3 on clock 0 (pin 0, enable route1), clear 0 global 0
    wr(12'h004, 32'h100);
    wr(12'h00c, 32'h1);
    wr(12'h160, 32'h4);
    u_fab.drive(0, 1, 1'b1);
    u_fab.drive(0, 2, 1'b1);
    for (int t = 0; t < 4; t++)
    begin
      wr(12'h04c, 32'h10 | t);
      u_fab.drive(2, 0, 1'b1);
      u_fab.drive(2, 0, 1'b0);
      mcheck(16'h8, 16'h0);
      u_fab.drive(1, 0, 1'b1);
      u_fab.drive(1, 0, 1'b0);
      mcheck(16'h8, 16'h8);
      u_fab.drive(1, 0, 1'b1);
      u_fab.drive(1, 0, 1'b0);
      mcheck(16'h8, (t == 1) ? 16'h0 : 16'h8);
    end
    // cell 7 on clock 1, pin 1 falling edge
    wr(12'h008, 32'h184);
    wr(12'h05c, 32'h8);
    wr(12'h1e0, 32'h4);
    u_fab.drive(1, 1, 1'b1);
    mcheck(16'h80, 16'h0);
    u_fab.drive(1, 1, 1'b0);
    mcheck(16'h80, 16'h80);
    // enable low: a toggle cell must ignore the tick
    u_fab.drive(0, 1, 1'b0);
    wr(12'h04c, 32'h11);
    u_fab.drive(1, 0, 1'b1);
    u_fab.drive(1, 0, 1'b0);
    mcheck(16'h8, 16'h8);
    // inverted clear with its global idle low
    wr(12'h00c, 32'h81);
    mcheck(16'h8, 16'h0);
    give_verdict();
  end
endmodule : ptm_block_tb
